//--- design/nvss_defines.vh
// Purpose: Constants for the nonvolatile SRAM host-side sequencer
// Assumes: 40 MHz ref_clk
// Notes: Pin timings expressed in ref_clk cycles
`ifndef NVSS_DEFINES_VH
`define NVSS_DEFINES_VH
`define NVSS_AW 13
`define NVSS_DW 8
`define NVSS_CLK_MHZ 40
`define NVSS_STORE_MS 10
`define NVSS_RECALL_US 20
`define NVSS_RESTORE_US 550
`define NVSS_STORE_CYC (`NVSS_STORE_MS * 1000 * `NVSS_CLK_MHZ)
`define NVSS_RECALL_CYC (`NVSS_RECALL_US * `NVSS_CLK_MHZ)
`define NVSS_RESTORE_CYC (`NVSS_RESTORE_US * `NVSS_CLK_MHZ)
`define NVSS_PULSE_CYC 4'h2
`define NVSS_SEQ0 13'h0000
`define NVSS_SEQ1 13'h1555
`define NVSS_SEQ2 13'h0aaa
`define NVSS_SEQ3 13'h1fff
`define NVSS_SEQ4 13'h10f0
`define NVSS_SEQ_STORE 13'h0f0f
`define NVSS_SEQ_RECALL 13'h0f0e
`define NVSS_LAST_STEP 3'h5
`define NVSS_OP_READ 2'h0
`define NVSS_OP_WRITE 2'h1
`define NVSS_OP_STORE 2'h2
`define NVSS_OP_RECALL 2'h3
`endif

//--- design/nvss_host.v
// Purpose: Host controller driving an 8K x 8 nonvolatile SRAM through its pins
// Assumes: Device pins sampled synchronously to ref_clk; one request at a time
// Notes: Store and recall are issued as six chip-select controlled reads
// Notes: Waits are fixed worst-case counts; the device is never polled
// Notes: A supply return seen mid-transfer is held and served once idle
// Notes: Every output is registered; read data is taken on the last pulse cycle
`default_nettype none
`include "nvss_defines.vh"
module nvss_host #(
    parameter STORE_CYC = `NVSS_STORE_CYC,
    parameter RESTORE_CYC = `NVSS_RESTORE_CYC,
    parameter RECALL_CYC = `NVSS_RECALL_CYC
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // User request
    input wire req_valid,
    input wire [1:0] req_op,
    input wire [12:0] req_addr,
    input wire [7:0] req_wdata,
    input wire power_restored,
    output reg req_ready,
    output reg rsp_valid,
    output reg [7:0] rsp_rdata,
    output reg busy,
    // Device pins
    output reg chip_select_n,
    output reg write_strobe_n,
    output reg output_drive_n,
    output reg [12:0] addr_bus,
    output reg [7:0] data_io_o,
    output reg data_io_oe,
    input wire [7:0] data_io_i
);
    localparam S_IDLE = 3'h0;
    localparam S_SETUP = 3'h1;
    localparam S_PULSE = 3'h2;
    localparam S_GAP = 3'h3;
    localparam S_WAIT = 3'h4;
    localparam S_ROMW = 3'h5;

    reg [2:0] state;
    reg [1:0] op;
    reg [2:0] step;
    reg [3:0] pcnt;
    reg [31:0] wcnt;
    reg [7:0] wdata;
    reg [12:0] uaddr;
    wire [12:0] seq_addr;
    wire is_seq;
    reg restore_pending;

    // Store and recall both run the six-read sequence
    function is_nv_op(input [1:0] kind);
        begin
            is_nv_op = (kind == `NVSS_OP_STORE) || (kind == `NVSS_OP_RECALL);
        end
    endfunction

    // Counts end at zero, so each load is one short of its length
    function [31:0] wait_load(input restore, input [1:0] kind);
        begin
            if (restore) begin
                wait_load = RESTORE_CYC - 1;
            end else if (kind == `NVSS_OP_STORE) begin
                wait_load = STORE_CYC - 1;
            end else begin
                wait_load = RECALL_CYC - 1;
            end
        end
    endfunction

    assign is_seq = is_nv_op(op);

    nvss_seq_rom u_rom (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .step(step),
        .is_recall(op == `NVSS_OP_RECALL),
        .seq_addr(seq_addr)
    );

    // A supply return seen mid-transfer is kept until idle so the power-up
    // wait is never skipped; in idle the flag clears, as a new return is served there at once
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            restore_pending <= 1'b0;
        end else if (power_restored && (state != S_IDLE)) begin
            restore_pending <= 1'b1;
        end else if (state == S_IDLE) begin
            restore_pending <= 1'b0;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
            op <= `NVSS_OP_READ;
            step <= 3'h0;
            pcnt <= 4'h0;
            wcnt <= 32'h0;
            wdata <= 8'h00;
            uaddr <= 13'h0000;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
            busy <= 1'b1;
            chip_select_n <= 1'b1;
            write_strobe_n <= 1'b1;
            output_drive_n <= 1'b1;
            addr_bus <= 13'h0000;
            data_io_o <= 8'h00;
            data_io_oe <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (power_restored || restore_pending) begin
                        // Pins idle high so no write is live when recall ends
                        wcnt <= wait_load(1'b1, op);
                        state <= S_WAIT;
                        busy <= 1'b1;
                        req_ready <= 1'b0;
                    end else if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        busy <= 1'b1;
                        op <= req_op;
                        uaddr <= req_addr;
                        wdata <= req_wdata;
                        step <= 3'h0;
                        state <= is_nv_op(req_op) ? S_ROMW : S_SETUP;
                    end else begin
                        req_ready <= 1'b1;
                        busy <= 1'b0;
                    end
                end
                S_ROMW: begin
                    state <= S_SETUP;
                end
                S_SETUP: begin
                    // Address settles before select falls and holds to its rise
                    addr_bus <= is_seq ? seq_addr : uaddr;
                    write_strobe_n <= 1'b1;
                    output_drive_n <= 1'b1;
                    pcnt <= `NVSS_PULSE_CYC;
                    state <= S_PULSE;
                end
                S_PULSE: begin
                    chip_select_n <= 1'b0;
                    if (op == `NVSS_OP_WRITE) begin
                        write_strobe_n <= 1'b0;
                        data_io_o <= wdata;
                        data_io_oe <= 1'b1;
                    end else if (op == `NVSS_OP_READ) begin
                        output_drive_n <= 1'b0;
                    end
                    if (pcnt == 4'h0) begin
                        if (op == `NVSS_OP_READ) begin
                            rsp_rdata <= data_io_i;
                        end
                        chip_select_n <= 1'b1;
                        write_strobe_n <= 1'b1;
                        output_drive_n <= 1'b1;
                        state <= S_GAP;
                    end else begin
                        pcnt <= pcnt - 4'h1;
                    end
                end
                S_GAP: begin
                    // Drop data only after the strobe has risen, giving hold time
                    data_io_oe <= 1'b0;
                    if (is_seq && step != `NVSS_LAST_STEP) begin
                        // Back-to-back reads only; nothing may interleave
                        step <= step + 3'h1;
                        state <= S_ROMW;
                    end else if (is_seq) begin
                        // Store lockout for a store; a recall loads its own far shorter count
                        wcnt <= wait_load(1'b0, op);
                        state <= S_WAIT;
                    end else begin
                        rsp_valid <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                S_WAIT: begin
                    // Pins held deselected so no write is live as a recall ends
                    chip_select_n <= 1'b1;
                    write_strobe_n <= 1'b1;
                    data_io_oe <= 1'b0;
                    if (wcnt == 32'h0) begin
                        rsp_valid <= 1'b1;
                        state <= S_IDLE;
                    end else begin
                        wcnt <= wcnt - 32'h1;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // nvss_host
`default_nettype wire

//--- design/nvss_seq_rom.v
// Purpose: Address list of the six-read store and recall sequences
// Assumes: Step 0 to 5; step 5 depends on store or recall
// Notes: Registered output, one cycle latency
`default_nettype none
`include "nvss_defines.vh"
module nvss_seq_rom (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Lookup
    input wire [2:0] step,
    input wire is_recall,
    output reg [12:0] seq_addr
);
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_addr <= 13'h0000;
        end else begin
            case (step)
                3'h0: seq_addr <= `NVSS_SEQ0;
                3'h1: seq_addr <= `NVSS_SEQ1;
                3'h2: seq_addr <= `NVSS_SEQ2;
                3'h3: seq_addr <= `NVSS_SEQ3;
                3'h4: seq_addr <= `NVSS_SEQ4;
                default: seq_addr <= is_recall ? `NVSS_SEQ_RECALL : `NVSS_SEQ_STORE;
            endcase
        end
    end
endmodule // nvss_seq_rom
`default_nettype wire

//--- verif/nvss_host_monitor.sv
// Purpose: Pin and handshake checks for nvss_host
// Assumes: All pins registered on ref_clk
// Notes: Bound to every nvss_host instance
`default_nettype none
module nvss_host_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // User side
    input wire logic power_restored,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic busy,
    // Device pins
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic output_drive_n,
    input wire logic [12:0] addr_bus,
    input wire logic data_io_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic wr = !chip_select_n && !write_strobe_n;
    AST_RD: assert property (!output_drive_n |-> write_strobe_n && !data_io_oe) else $error("rd");
    AST_WR: assert property (wr |-> data_io_oe && output_drive_n) else $error("wr");
    AST_WADR: assert property (wr && $past(wr) |-> $stable(addr_bus)) else $error("wadr");
    AST_PUL: assert property (
        $fell(chip_select_n) |=> !chip_select_n ##[1:3] chip_select_n) else $error("pulse");
    AST_CADR: assert property (
        !chip_select_n && !$fell(chip_select_n) |-> $stable(addr_bus)) else $error("cadr");
    AST_IDLE: assert property (
        req_ready |-> chip_select_n && write_strobe_n && !data_io_oe) else $error("idle");
    AST_RSP: assert property (
        rsp_valid |=> !rsp_valid && (req_ready != busy)) else $error("rsp");
    AST_PWR: assert property (
        power_restored && req_ready |=> busy && !req_ready) else $error("power wait");
    AST_END: assert property ($rose(write_strobe_n) |=> !data_io_oe) else $error("end");
    cover property (wr);
    cover property (!output_drive_n);
    cover property (rsp_valid);
    cover property (power_restored && req_ready);
endmodule // nvss_host_monitor
bind nvss_host nvss_host_monitor u_nvss_host_monitor (.ref_clk(ref_clk), .rst_n(rst_n),
    .power_restored(power_restored), .busy(busy),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .chip_select_n(chip_select_n),
    .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n),
    .addr_bus(addr_bus), .data_io_oe(data_io_oe));
`default_nettype wire

//--- verif/nvss_mem_model.sv
// Purpose: Behavioural 8K x 8 nonvolatile SRAM
// Assumes: Pins sampled on ref_clk; a step counts at chip-select rise
// Notes: Busy windows shorter than the host waits; power_restored reloads the SRAM from the nonvolatile array
`default_nettype none
module nvss_mem_model #(parameter int HOLD = 6) (
    // Clock and pins
    input wire logic ref_clk,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic output_drive_n,
    input wire logic [12:0] addr_bus,
    input wire logic [7:0] data_in,
    input wire logic power_restored,
    // Device drive
    output logic [7:0] dq_o,
    output logic dq_en
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sram [0:8191];
    logic [7:0] nv [0:8191];
    logic [12:0] seq [0:5] = '{13'h0000, 13'h1555, 13'h0aaa, 13'h1fff, 13'h10f0, 13'h0f0e};
    logic [7:0] last = 8'h00;
    logic [12:0] addr_q = 13'h0000;
    logic cs_q = 1'b1;
    logic wseen = 1'b0;
    int step = 0;
    int hold = 0;
    initial for (int i = 0; i < 8192; i++) nv[i] = 8'h00;
    assign dq_en = !chip_select_n && !output_drive_n && write_strobe_n && hold == 0;
    // Released bus toggles, so stale data never reads as valid
    assign dq_o = dq_en ? sram[addr_bus] : ~last;
    always @(posedge ref_clk) begin
        cs_q <= chip_select_n;
        last <= dq_o;
        if (hold > 0) begin
            hold <= hold - 1;
        end else if (power_restored) begin
            hold <= HOLD;
            for (int i = 0; i < 8192; i++) sram[i] <= nv[i];
        end else if (!chip_select_n) begin
            if (!write_strobe_n) sram[addr_bus] <= data_in;
            wseen <= wseen | !write_strobe_n;
            addr_q <= addr_bus;
        end else if (!cs_q) begin
            wseen <= 1'b0;
            if (wseen || (addr_q & ~13'(step == 5)) != seq[step]) begin
                step <= 0;
            end else if (step < 5) begin
                step <= step + 1;
            end else begin
                step <= 0;
                hold <= HOLD;
                for (int i = 0; i < 8192; i++)
                    if (addr_q[0]) nv[i] <= sram[i]; else sram[i] <= nv[i];
            end
        end
    end
endmodule // nvss_mem_model
`default_nettype wire

//--- verif/test_nvss_host.sv
// Purpose: Self-checking bench for nvss_host
// Assumes: Store, recall and power-up waits shortened to 8 cycles
// Notes: Device model answers faster than the host waits
`default_nettype none
module test_nvss_host;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic [1:0] req_op = 2'h0;
    logic [12:0] req_addr = 13'h0000;
    logic [7:0] req_wdata = 8'h00;
    logic power_restored = 1'b0;
    logic req_ready, rsp_valid, busy, cs_n, we_n, oe_n, oe;
    logic [7:0] rsp_rdata, dq_host, dq_dev;
    logic [12:0] addr;
    wire logic [7:0] dq = oe ? dq_host : dq_dev;
    int n_fail = 0;
    int checks_done = 0;
    nvss_host #(.STORE_CYC(8), .RESTORE_CYC(8), .RECALL_CYC(8)) u_nvss_host (
        .ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_wdata(req_wdata), .power_restored(power_restored),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy),
        .chip_select_n(cs_n), .write_strobe_n(we_n), .output_drive_n(oe_n),
        .addr_bus(addr), .data_io_o(dq_host), .data_io_oe(oe), .data_io_i(dq));
    nvss_mem_model u_nvss_mem_model (.ref_clk(ref_clk), .chip_select_n(cs_n),
        .write_strobe_n(we_n), .output_drive_n(oe_n), .addr_bus(addr), .data_in(dq),
        .power_restored(power_restored), .dq_o(dq_dev), .dq_en());
    initial forever #12.5 ref_clk = ~ref_clk;
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic wait_rsp(input int n);
        do @(posedge ref_clk); while (rsp_valid !== 1'b1 && ++n < 300);
        if (n >= 300) begin
            n_fail++;
            give_verdict();
        end
    endtask
    task automatic op(input logic [1:0] o, input logic [12:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge ref_clk);
        chk_bit("busy before request", 1'b0, busy);
        req_valid <= 1'b1;
        req_op <= o;
        req_addr <= a;
        req_wdata <= d;
        do @(posedge ref_clk); while (req_ready !== 1'b1 && ++n < 50);
        req_valid <= 1'b0;
        if (n >= 50) begin
            n_fail++;
            give_verdict();
        end
        wait_rsp(n);
        chk_bit("busy at answer", 1'b1, busy);
    endtask
    task automatic t_rw();
        logic [12:0] a [3] = '{13'h0000, 13'h1fff, 13'h0aaa};
        logic [7:0] d [3] = '{8'ha5, 8'h5a, 8'hc3};
        foreach (a[i]) op(2'h1, a[i], d[i]);
        foreach (a[i]) begin
            op(2'h0, a[i], 8'h00);
            chk("read data", d[i], rsp_rdata);
        end
        $display("t_rw done");
    endtask
    task automatic t_store_recall();
        op(2'h1, 13'h0123, 8'h5a);
        op(2'h2, 13'h0000, 8'h00);
        op(2'h1, 13'h0123, 8'ha5);
        op(2'h0, 13'h0123, 8'h00);
        chk("sram after store", 8'ha5, rsp_rdata);
        op(2'h3, 13'h0000, 8'h00);
        op(2'h0, 13'h0123, 8'h00);
        chk("recalled data", 8'h5a, rsp_rdata);
        $display("t_store_recall done");
    endtask
    task automatic t_power();
        op(2'h1, 13'h0123, 8'h77);
        @(posedge ref_clk);
        power_restored <= 1'b1;
        @(posedge ref_clk);
        power_restored <= 1'b0;
        wait_rsp(0);
        chk_bit("busy in power wait", 1'b1, busy);
        op(2'h0, 13'h0123, 8'h00);
        chk("power-up recall", 8'h5a, rsp_rdata);
        $display("t_power done");
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_rw();
        t_store_recall();
        t_power();
        give_verdict();
    end
endmodule // test_nvss_host
`default_nettype wire
